// [core/atf_pkg.sv]
// task file register set constants, shared by the core modules
// assumes a register port addressed by a 4-bit index from the link layer
// Function
// - error bits explain every error status
// - bad block bit7, uncorrectable bit6, zeros
// - abort bit2 on refusal or bad opcode
// - id-not-found bit4, general error bit0
// - sector count zero means 256 sectors
// - count zero on success, remainder on failure
// - block address assembled from four registers
// - unit select bit6 picks chs or lba
// - busy locks host out, hides status
// - ready clear until commands accepted
// - write fault bit5, seek complete bit4
// - transfer request bit3 while data pending
// - corrected bit2, read continues
// - error bit0, bit1 always zero
// - status read clears interrupt, aux not
// - bit7 selects previous value readback
// - soft reset held while bit2 set
// - bit1 active-low interrupt enable, zero reset
// - control bits 6..3 and 0 ignored
// - unit address bit6 write, inverted heads
// - unit address bits 1,0 select low
package atf_pkg;
    localparam logic [3:0] ATF_IDX_DATA    = 4'h0;
    localparam logic [3:0] ATF_IDX_ERRFEAT = 4'h1;
    localparam logic [3:0] ATF_IDX_COUNT   = 4'h2;
    localparam logic [3:0] ATF_IDX_ADDR0   = 4'h3;
    localparam logic [3:0] ATF_IDX_ADDR1   = 4'h4;
    localparam logic [3:0] ATF_IDX_ADDR2   = 4'h5;
    localparam logic [3:0] ATF_IDX_UNIT    = 4'h6;
    localparam logic [3:0] ATF_IDX_STATE   = 4'h7;
    localparam logic [3:0] ATF_IDX_CTRL    = 4'h8;
    localparam logic [3:0] ATF_IDX_AUX     = 4'h9;
    localparam logic [3:0] ATF_IDX_UADDR   = 4'ha;
    localparam int ATF_ERR_BAD   = 7;
    localparam int ATF_ERR_UNCOR = 6;
    localparam int ATF_ERR_NOID  = 4;
    localparam int ATF_ERR_ABORT = 2;
    localparam int ATF_ERR_GEN   = 0;
    localparam int ATF_ST_BUSY   = 7;
    localparam int ATF_ST_RDY    = 6;
    localparam int ATF_ST_WF     = 5;
    localparam int ATF_ST_SC     = 4;
    localparam int ATF_ST_REQ    = 3;
    localparam int ATF_ST_FIXED  = 2;
    localparam int ATF_ST_ERR    = 0;
    localparam int ATF_CTL_PREV  = 7;
    localparam int ATF_CTL_SRST  = 2;
    localparam int ATF_CTL_MASK  = 1;
    localparam int ATF_UNIT_LBA  = 6;
    localparam int ATF_UNIT_NUM  = 4;
    localparam logic [7:0] ATF_UNIT_RST  = 8'ha0;
    localparam logic [7:0] ATF_CTRL_RST  = 8'h00;
    localparam logic [8:0] ATF_FULL_CNT  = 9'h100;
    localparam int ATF_DATA_W    = 16;
    localparam int ATF_FIFO_D    = 4;
    typedef enum logic [1:0] {
        ATF_IDLE, ATF_XFER, ATF_DONE
    } atf_phase_t;
endpackage : atf_pkg

// [core/atf_stream_if.sv]
// valid/ready data path between the register file and the fifo
// assumes one clock shared by both ends
interface atf_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : atf_stream_if

// [core/atf_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
// assumes a synchronous active-low reset
module atf_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    atf_stream_if.snk in_s,
    atf_stream_if.src out_s
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wr_reg, rd_reg;
    logic [AW:0]   cnt_reg;
    wire push = in_s.valid && in_s.ready;
    wire pop  = out_s.valid && out_s.ready;
    assign in_s.ready  = (cnt_reg != (AW+1)'(D));
    assign out_s.valid = (cnt_reg != '0);
    assign out_s.data  = mem_reg[rd_reg];
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= AW'((wr_reg + 1'b1) % D);
            if (pop) rd_reg <= AW'((rd_reg + 1'b1) % D);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clock) begin
        if (push) mem_reg[wr_reg] <= in_s.data;
    end
endmodule : atf_fifo

// [core/atf_task_file.sv]
// task file register set of the storage device
// assumes the link layer presents decoded register accesses on clock
module atf_task_file
    import atf_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [3:0]  reg_idx,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_wr_ready,
    output logic      [15:0] core_wdata,
    output logic             core_wvalid,
    input  wire logic        core_wready,
    input  wire logic        core_ready,
    input  wire logic        core_busy,
    input  wire logic        core_xfer,
    input  wire logic        core_writing,
    input  wire logic        core_done,
    input  wire logic        core_fail,
    input  wire logic        core_sector,
    input  wire logic        ev_bad_block,
    input  wire logic        ev_uncorrectable,
    input  wire logic        ev_id_missing,
    input  wire logic        ev_aborted,
    input  wire logic        ev_general,
    input  wire logic        ev_write_fault,
    input  wire logic        ev_corrected,
    input  wire logic        ev_irq,
    output logic             cmd_start,
    output logic             lba_mode,
    output logic      [27:0] block_addr,
    output logic      [8:0]  sectors_req,
    output logic      [7:0]  feature_out,
    output logic             soft_reset,
    output logic             intrq
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] err_reg, feat_reg;
    logic [7:0] cnt_reg, a0_reg, a1_reg, a2_reg, unit_reg;
    logic [7:0] cnt_prev_reg, a0_prev_reg, a1_prev_reg, a2_prev_reg;
    logic [7:0] unit_prev_reg, ctrl_reg;
    logic wf_reg, corrected_error_flag_reg, errst_reg, pend_reg;
    atf_phase_t phase_reg, phase_next;

    atf_stream_if #(.W(ATF_DATA_W)) fin();
    atf_stream_if #(.W(ATF_DATA_W)) fout();

    atf_fifo #(.W(ATF_DATA_W), .D(ATF_FIFO_D)) u_fifo (
        .clock (clock),
        .rst_b (rst_b),
        .in_s  (fin),
        .out_s (fout)
    );

    ////////////////////////////////////////////////////////////////////
    wire wr_data  = reg_wr && (reg_idx == ATF_IDX_DATA);
    wire wr_feat  = reg_wr && (reg_idx == ATF_IDX_ERRFEAT);
    wire wr_cnt   = reg_wr && (reg_idx == ATF_IDX_COUNT);
    wire wr_a0    = reg_wr && (reg_idx == ATF_IDX_ADDR0);
    wire wr_a1    = reg_wr && (reg_idx == ATF_IDX_ADDR1);
    wire wr_a2    = reg_wr && (reg_idx == ATF_IDX_ADDR2);
    wire wr_unit  = reg_wr && (reg_idx == ATF_IDX_UNIT);
    wire wr_cmd   = reg_wr && (reg_idx == ATF_IDX_STATE);
    wire wr_ctrl  = reg_wr && (reg_idx == ATF_IDX_CTRL);
    wire rd_state = reg_rd && (reg_idx == ATF_IDX_STATE);
    // busy locks the host out of the command block
    wire host_ok  = !core_busy;
    wire blk_wr   = host_ok && (wr_feat || wr_cnt || wr_a0 || wr_a1 ||
                    wr_a2 || wr_unit || wr_cmd);
    wire prev_sel = ctrl_reg[ATF_CTL_PREV];

    // data words go to the core through the fifo; back-pressure shows
    assign fin.valid      = wr_data && host_ok && core_xfer;
    assign fin.data       = reg_wdata;
    assign reg_wr_ready   = fin.ready;
    assign core_wvalid    = fout.valid;
    assign core_wdata     = fout.data;
    assign fout.ready     = core_wready;

    ////////////////////////////////////////////////////////////////////
    // sticky error causes; cleared when the next command starts
    wire [7:0] err_new = {ev_bad_block, ev_uncorrectable, 1'b0,
                          ev_id_missing, 1'b0, ev_aborted, 1'b0,
                          ev_general};
    wire any_err = |err_new;
    wire [7:0] err_next = (wr_cmd && host_ok) ? err_new
                                             : (err_reg | err_new);

    // remaining-sector bookkeeping
    wire [8:0] cnt_full = (cnt_reg == 8'h00) ? ATF_FULL_CNT
                                             : {1'b0, cnt_reg};
    // sectors only count down while a command is running
    wire in_xfer = (phase_reg == ATF_XFER);
    wire [7:0] cnt_dec = (in_xfer && core_sector && cnt_reg != 8'h00)
                         ? cnt_reg - 8'h01 : cnt_reg;
    // success leaves zero, failure leaves the remainder
    wire [7:0] cnt_next = core_done ? 8'h00 : cnt_dec;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            ATF_IDLE: if (wr_cmd && host_ok) phase_next = ATF_XFER;
            ATF_XFER: if (core_done || core_fail) phase_next = ATF_DONE;
            ATF_DONE: if (wr_cmd && host_ok) phase_next = ATF_XFER;
            default:  phase_next = ATF_IDLE;
        endcase
    end

    wire srst = ctrl_reg[ATF_CTL_SRST];
    assign soft_reset = srst;

    always_ff @(posedge clock) begin
        if (!rst_b || srst) begin
            phase_reg <= ATF_IDLE;
            err_reg   <= 8'h00;
            wf_reg    <= 1'b0;
            corrected_error_flag_reg  <= 1'b0;
            errst_reg <= 1'b0;
            pend_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            err_reg   <= err_next;
            // error status set together with its cause bits
            errst_reg <= any_err | (errst_reg & ~(wr_cmd & host_ok));
            wf_reg    <= ev_write_fault | (wf_reg & ~(wr_cmd & host_ok));
            // correction flags only; the read keeps going
            corrected_error_flag_reg  <= ev_corrected | (corrected_error_flag_reg & ~(wr_cmd & host_ok));
            // a new event wins over the clearing status read
            pend_reg  <= ev_irq | (pend_reg & ~rd_state);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // previous-value copies follow each write of the register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_reg  <= 8'h00;
            a0_reg   <= 8'h00;
            a1_reg   <= 8'h00;
            a2_reg   <= 8'h00;
            unit_reg <= ATF_UNIT_RST;
            feat_reg <= 8'h00;
            cnt_prev_reg  <= 8'h00;
            a0_prev_reg   <= 8'h00;
            a1_prev_reg   <= 8'h00;
            a2_prev_reg   <= 8'h00;
            unit_prev_reg <= ATF_UNIT_RST;
        end else if (host_ok && reg_wr) begin
            if (wr_feat) feat_reg <= reg_wdata[7:0];
            if (wr_cnt) begin
                cnt_prev_reg <= cnt_reg;
                cnt_reg      <= reg_wdata[7:0];
            end
            if (wr_a0) begin
                a0_prev_reg <= a0_reg;
                a0_reg      <= reg_wdata[7:0];
            end
            if (wr_a1) begin
                a1_prev_reg <= a1_reg;
                a1_reg      <= reg_wdata[7:0];
            end
            if (wr_a2) begin
                a2_prev_reg <= a2_reg;
                a2_reg      <= reg_wdata[7:0];
            end
            if (wr_unit) begin
                unit_prev_reg <= unit_reg;
                // host must write 1x1 0; the unit bit is stored as given
                unit_reg      <= reg_wdata[7:0];
            end
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // only readback select, soft reset and mask kept; 6..3, 0 dropped
    wire [7:0] ctrl_w = {reg_wdata[ATF_CTL_PREV], 4'h0,
                         reg_wdata[ATF_CTL_SRST],
                         reg_wdata[ATF_CTL_MASK], 1'b0};
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_reg <= ATF_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= ctrl_w;
        end else if (blk_wr) begin
            ctrl_reg[ATF_CTL_PREV] <= 1'b0;
        end else if (srst) begin
            ctrl_reg[ATF_CTL_MASK] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign lba_mode    = unit_reg[ATF_UNIT_LBA];
    assign block_addr  = {unit_reg[3:0], a2_reg, a1_reg, a0_reg};
    assign sectors_req = cnt_full;
    assign feature_out = feat_reg;
    assign cmd_start   = wr_cmd && host_ok;
    // masked interrupt leaves the pending flag untouched
    assign intrq = pend_reg && !ctrl_reg[ATF_CTL_MASK];

    wire rdy_now = core_ready && !srst;
    wire [7:0] st_val = core_busy ? 8'h80
        : {1'b0, rdy_now, wf_reg, rdy_now,
           core_xfer, corrected_error_flag_reg, 1'b0, errst_reg};
    wire [7:0] ua_val = {1'b0, !core_writing, ~unit_reg[3:0],
                         ~unit_reg[ATF_UNIT_NUM],
                         unit_reg[ATF_UNIT_NUM]};
    wire [7:0] sel_cnt  = prev_sel ? cnt_prev_reg  : cnt_reg;
    wire [7:0] sel_a0   = prev_sel ? a0_prev_reg   : a0_reg;
    wire [7:0] sel_a1   = prev_sel ? a1_prev_reg   : a1_reg;
    wire [7:0] sel_a2   = prev_sel ? a2_prev_reg   : a2_reg;
    wire [7:0] sel_unit = prev_sel ? unit_prev_reg : unit_reg;

    logic [7:0] rd_mux;
    always_comb begin
        case (reg_idx)
            ATF_IDX_ERRFEAT: rd_mux = err_reg;
            ATF_IDX_COUNT:   rd_mux = sel_cnt;
            ATF_IDX_ADDR0:   rd_mux = sel_a0;
            ATF_IDX_ADDR1:   rd_mux = sel_a1;
            ATF_IDX_ADDR2:   rd_mux = sel_a2;
            ATF_IDX_UNIT:    rd_mux = sel_unit;
            ATF_IDX_STATE:   rd_mux = st_val;
            ATF_IDX_AUX:     rd_mux = st_val;
            ATF_IDX_UADDR:   rd_mux = ua_val;
            default:         rd_mux = 8'h00;
        endcase
    end

    // read data registered; reads of data port return zero here
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= {8'h00, rd_mux};
        end
    end
endmodule : atf_task_file

// [tb/atf_assertions.sv]
// checker for the task file register port
// assumes it is bound to atf_task_file and sees only its ports
module atf_assertions
    import atf_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [3:0]  reg_idx,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        core_busy,
    input wire logic        core_writing,
    input wire logic        ev_irq,
    input wire logic        cmd_start,
    input wire logic        lba_mode,
    input wire logic [27:0] block_addr,
    input wire logic [8:0]  sectors_req,
    input wire logic        soft_reset,
    input wire logic        intrq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // soft reset does not hold off command block writes; it is excluded here along with busy
    wire logic cb_wr = reg_wr && !core_busy && !soft_reset;
    wire logic st_rd = reg_rd && reg_idx == ATF_IDX_STATE;
    wire logic ct_wr = reg_wr && reg_idx == ATF_IDX_CTRL;
    ////////////////////////////////////////////////////////////////////////
    chk_count_full:
        assert property (cb_wr && reg_idx == ATF_IDX_COUNT && reg_wdata[7:0]
            == 8'h00 |=> sectors_req == ATF_FULL_CNT) else $error("count");
    chk_head_bits:
        assert property (cb_wr && reg_idx == ATF_IDX_UNIT && reg_wdata[6]
            |=> block_addr[27:24] == $past(reg_wdata[3:0]))
            else $error("head");
    chk_lba_select:
        assert property (cb_wr && reg_idx == ATF_IDX_UNIT
            |=> lba_mode == $past(reg_wdata[6])) else $error("lba mode");
    chk_busy_lock:
        assert property (reg_wr && reg_idx == ATF_IDX_STATE && core_busy
            |-> !cmd_start) else $error("command taken while busy");
    chk_status_zero:
        assert property (st_rd && !core_busy |=> reg_rdata[1] == 1'h0)
            else $error("status bit1");
    chk_status_clear:
        assert property (st_rd && !ev_irq |=> !intrq) else $error("irq kept");
    chk_aux_keep:
        assert property (intrq && reg_rd && reg_idx == ATF_IDX_AUX && !reg_wr
            |=> intrq) else $error("aux read cleared irq");
    chk_soft_hold:
        assert property (ct_wr |=> soft_reset == $past(reg_wdata[2]))
            else $error("soft reset level");
    chk_mask_irq:
        assert property (ct_wr && reg_wdata[ATF_CTL_MASK] |=> !intrq)
            else $error("masked irq seen");
    chk_write_flag:
        assert property (reg_rd && reg_idx == ATF_IDX_UADDR
            |=> reg_rdata[6] == !$past(core_writing))
            else $error("write flag");
    cov_irq_clear: cover property (st_rd && intrq);
    cov_full: cover property (sectors_req == ATF_FULL_CNT);
    cov_soft: cover property (soft_reset);
endmodule : atf_assertions

bind atf_task_file atf_assertions chk (
    .clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .core_busy(core_busy), .core_writing(core_writing), .ev_irq(ev_irq),
    .cmd_start(cmd_start), .lba_mode(lba_mode), .block_addr(block_addr),
    .sectors_req(sectors_req), .soft_reset(soft_reset), .intrq(intrq));

// [tb/atf_host_model.sv]
// host side of the register port: write and read tasks
// assumes callers act just after a rising edge of clock
module atf_host_model
    import atf_pkg::*;
(
    input  wire logic        clock,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_wr_ready,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [3:0]       reg_idx,
    output logic [15:0]      reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_idx = 4'h0;
        reg_wdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    task wr(input logic [3:0] i, input logic [15:0] d);
        @(posedge clock) #1;
        // data words wait for room rather than being dropped
        while (i == ATF_IDX_DATA && reg_wr_ready !== 1'h1) @(posedge clock) #1;
        reg_idx = i;
        reg_wdata = (i == ATF_IDX_UNIT) ? {d[15:8], 1'b1, d[6], 2'h2, d[3:0]}
                                        : d;
        reg_wr = 1'h1;
        @(posedge clock) #1;
        reg_wr = 1'h0;
        // released data no longer carries the old value
        reg_wdata = ~reg_wdata;
    endtask : wr
    task rd(input logic [3:0] i, output logic [15:0] d);
        @(posedge clock) #1;
        reg_idx = i;
        reg_rd = 1'h1;
        @(posedge clock) #1;
        reg_rd = 1'h0;
        d = reg_rdata;
    endtask : rd
endmodule : atf_host_model

// [tb/atf_task_file_test.sv]
// self-checking bench for the task file register set
// assumes the host model and the bound checker sit beside the dut
module atf_task_file_test
    import atf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0;
    logic rst_b, core_wready, core_ready, core_busy, core_xfer, core_writing;
    logic [10:0] ev;
    logic [15:0] v, reg_rdata, reg_wdata, core_wdata;
    logic [3:0] reg_idx;
    logic [27:0] block_addr;
    logic [8:0] sectors_req;
    logic reg_wr, reg_rd, reg_wr_ready, core_wvalid, lba_mode;
    logic soft_reset, intrq;
    logic [7:0] feature_out;
    logic [7:0] codes [5] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01};
    int n_errors = 0;
    int checks = 0;
    always #12.5 clock = ~clock;
    atf_host_model host (.clock(clock), .reg_rdata(reg_rdata),
        .reg_wr_ready(reg_wr_ready), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_idx(reg_idx), .reg_wdata(reg_wdata));
    atf_task_file dut (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_wr_ready(reg_wr_ready),
        .core_wdata(core_wdata), .core_wvalid(core_wvalid),
        .core_wready(core_wready), .core_ready(core_ready),
        .core_busy(core_busy), .core_xfer(core_xfer),
        .core_writing(core_writing), .core_done(ev[10]), .core_fail(ev[9]),
        .core_sector(ev[8]), .ev_bad_block(ev[7]), .ev_uncorrectable(ev[6]),
        .ev_write_fault(ev[5]), .ev_id_missing(ev[4]), .ev_irq(ev[3]),
        .ev_aborted(ev[2]), .ev_corrected(ev[1]), .ev_general(ev[0]),
        .cmd_start(), .lba_mode(lba_mode), .block_addr(block_addr),
        .sectors_req(sectors_req), .feature_out(feature_out),
        .soft_reset(soft_reset), .intrq(intrq));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [27:0] got, exp, input string nm);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task fire(input logic [10:0] e);
        @(posedge clock) #1;
        ev = e;
        @(posedge clock) #1;
        ev = 11'h000;
    endtask : fire
    task print_verdict;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        host.rd(ATF_IDX_STATE, v);
        chk(v[6], 1'h0, "ready at reset");
        chk(v[1], 1'h0, "status bit1");
        chk(intrq, 1'h0, "irq at reset");
        host.rd(ATF_IDX_UADDR, v);
        chk(v[6:0], 7'h7e, "unit address");
    endtask : t_reset
    task t_addr;
        host.wr(ATF_IDX_ERRFEAT, 16'h00ef);
        chk(feature_out, 8'hef, "feature");
        host.wr(ATF_IDX_COUNT, 16'h0000);
        host.wr(ATF_IDX_ADDR0, 16'h0012);
        host.wr(ATF_IDX_ADDR1, 16'h0034);
        host.wr(ATF_IDX_ADDR2, 16'h0056);
        host.wr(ATF_IDX_UNIT, 16'h0045);
        chk(block_addr, 28'h556_3412, "block address");
        chk(sectors_req, 9'h100, "full count");
        chk(lba_mode, 1'h1, "lba mode");
        host.wr(ATF_IDX_UNIT, 16'h0005);
        chk(lba_mode, 1'h0, "chs mode");
        host.wr(ATF_IDX_COUNT, 16'h0005);
        host.wr(ATF_IDX_COUNT, 16'h0009);
        host.wr(ATF_IDX_CTRL, 16'h0080);
        host.rd(ATF_IDX_COUNT, v);
        chk(v[7:0], 8'h05, "previous count");
        host.wr(ATF_IDX_ADDR0, 16'h0012);
        host.rd(ATF_IDX_COUNT, v);
        chk(v[7:0], 8'h09, "latest count");
    endtask : t_addr
    task t_errors;
        for (int k = 0; k < 5; k++) begin
            host.wr(ATF_IDX_STATE, 16'h0020);
            fire({3'h2, codes[k]});
            host.rd(ATF_IDX_ERRFEAT, v);
            chk(v[7:0], codes[k], "error cause");
            host.rd(ATF_IDX_STATE, v);
            chk(v[0], 1'h1, "error status");
        end
        host.wr(ATF_IDX_COUNT, 16'h0003);
        host.wr(ATF_IDX_STATE, 16'h0020);
        fire(11'h100);
        fire(11'h200);
        host.rd(ATF_IDX_COUNT, v);
        chk(v[7:0], 8'h02, "count left");
        host.wr(ATF_IDX_STATE, 16'h0020);
        fire(11'h400);
        host.rd(ATF_IDX_COUNT, v);
        chk(v[7:0], 8'h00, "count done");
    endtask : t_errors
    task t_status;
        core_xfer = 1'h1;
        fire(11'h022);
        host.rd(ATF_IDX_STATE, v);
        chk(v[6:1], 6'h3e, "status flags");
        core_busy = 1'h1;
        host.wr(ATF_IDX_COUNT, 16'h0077);
        host.wr(ATF_IDX_STATE, 16'h0020);
        host.rd(ATF_IDX_STATE, v);
        chk(v[7], 1'h1, "busy");
        core_busy = 1'h0;
        host.rd(ATF_IDX_COUNT, v);
        chk(v[7:0], 8'h00, "write while busy");
        core_writing = 1'h1;
        host.rd(ATF_IDX_UADDR, v);
        chk(v[6], 1'h0, "writing");
        core_writing = 1'h0;
    endtask : t_status
    task t_irq;
        fire(11'h008);
        chk(intrq, 1'h1, "irq raised");
        host.rd(ATF_IDX_AUX, v);
        chk(intrq, 1'h1, "irq after aux");
        host.rd(ATF_IDX_STATE, v);
        chk(intrq, 1'h0, "irq after status");
        host.wr(ATF_IDX_CTRL, 16'h0002);
        fire(11'h008);
        chk(intrq, 1'h0, "irq masked");
        host.wr(ATF_IDX_CTRL, 16'h0079);
        chk(intrq, 1'h1, "irq unmasked");
        chk(soft_reset, 1'h0, "ignored bits");
        host.wr(ATF_IDX_CTRL, 16'h0004);
        chk(soft_reset, 1'h1, "soft reset on");
        host.rd(ATF_IDX_STATE, v);
        chk(v[6], 1'h0, "ready in soft reset");
        host.wr(ATF_IDX_CTRL, 16'h0000);
        chk(soft_reset, 1'h0, "soft reset off");
    endtask : t_irq
    task t_fifo;
        // far side stalls while the buffer fills
        for (int k = 0; k < ATF_FIFO_D; k++) begin
            host.wr(ATF_IDX_DATA, 16'(16'ha5a0 + k));
        end
        chk(reg_wr_ready, 1'h0, "buffer full");
        core_wready = 1'h1;
        for (int k = 0; k < ATF_FIFO_D; k++) begin
            chk(core_wvalid, 1'h1, "word valid");
            chk(core_wdata, 16'(16'ha5a0 + k), "word order");
            @(posedge clock) #1;
        end
        chk(core_wvalid, 1'h0, "buffer empty");
    endtask : t_fifo
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'h0;
        {core_wready, core_ready, core_busy, core_xfer, core_writing} = 5'h00;
        ev = 11'h000;
        repeat (2) @(posedge clock);
        #1 rst_b = 1'h1;
        t_reset;
        core_ready = 1'h1;
        t_addr;
        t_errors;
        t_status;
        t_irq;
        t_fifo;
        print_verdict;
    end
    initial begin
        #100_000;
        n_errors++;
        print_verdict;
    end
endmodule : atf_task_file_test
